// >>> dv/wit_checker.sv
`timescale 1ns/1ns
module wit_checker #(parameter PULSE_CYC = 132) (
  input logic sys_clk,
  input logic nrst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [15:0] wb_adr_i,
  input logic [1:0] wb_sel_i,
  input logic [15:0] wb_dat_o,
  input logic wb_ack_o,
  input logic standby_req,
  input logic interval_irq,
  input logic chip_reset_out,
  input logic res_pin_out,
  input logic res_pin_oe_n
);
  logic [8:0] hi_reg;
  // pulse length counter; a repetition of 132 would be too costly to unroll
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) hi_reg <= 9'h000;
    else hi_reg <= chip_reset_out ? hi_reg + 9'h001 : 9'h000;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_ack;
    wb_ack_o && !wb_we_i;
  endsequence
  a_ack_follows: assert property (s_req |=> wb_ack_o)
    else $error("request not answered");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (s_rd_ack ##0 (wb_adr_i[15:1] != 15'h7f76
    && wb_adr_i[15:1] != 15'h7f8a) |-> wb_dat_o == 16'h0000) else $error("unmapped read not zero");
  a_rst_ones: assert property (s_rd_ack ##0 (wb_adr_i[15:1] == 15'h7f8a && wb_sel_i[0])
    |-> wb_dat_o[5:0] == 6'h3f) else $error("reset ctrl low bits");
  a_irq_holds: assert property (interval_irq && !standby_req && !(wb_ack_o && wb_we_i) |=> interval_irq)
    else $error("irq dropped without clear");
  a_no_irq_wd: assert property (chip_reset_out |-> !interval_irq)
    else $error("irq during watchdog reset");
  a_pulse_len: assert property ($fell(chip_reset_out) |-> hi_reg == PULSE_CYC)
    else $error("reset pulse length wrong");
  a_pin_in_pulse: assert property (!res_pin_oe_n |-> chip_reset_out && !res_pin_out)
    else $error("pin driven outside pulse");
endmodule // wit_checker

bind wit_top wit_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .standby_req, .interval_irq, .chip_reset_out, .res_pin_out,
  .res_pin_oe_n);

// >>> dv/wit_tb_top.sv
`timescale 1ns/1ns
`include "wit_consts.vh"
module wit_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sby = 1'b0;
  logic [1:0] sel = 2'b11;
  logic [15:0] adr = 16'h0000;
  logic [15:0] wdat = 16'h0000;
  logic [15:0] rdat, rd;
  logic ack, irq, crst, pout, poe_n;
  int err_count = 0;
  int checked = 0;
  int n;
  // 50 ns period
  always #25 sys_clk = ~sys_clk;
  wit_top dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .standby_req(sby), .interval_irq(irq),
    .chip_reset_out(crst), .res_pin_in(1'b1), .res_pin_out(pout), .res_pin_oe_n(poe_n));
  task close_out;
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // request held until ack is sampled; a missing ack is a mismatch, not a hang
  task wb(input logic w, input logic [15:0] a, input logic [1:0] s, input logic [15:0] d);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({15'h0000, ack}, 16'h0001);
  endtask
  task rdc(input logic [15:0] a, input logic [15:0] e);
    wb(1'b0, a, 2'b11, 16'h0000);
    chk(rd, e);
  endtask
  task t_reset_vals;
    rdc(16'hfeec, 16'h1800);
    rdc(16'hff14, 16'h003f);
    rdc(16'h1230, 16'h0000);
  endtask
  task t_password;
    wb(1'b1, 16'hfeec, 2'b11, 16'h1227);
    wb(1'b1, 16'hfeec, 2'b10, 16'ha527);
    rdc(16'hfeec, 16'h1800);
    wb(1'b1, 16'hfeec, 2'b11, 16'ha5a7);
    wb(1'b1, 16'hfeec, 2'b11, 16'h5a42);
    wb(1'b0, 16'hfeec, 2'b11, 16'h0000);
    chk({rd[15:1], 1'b0}, 16'h3f42);
    wb(1'b1, 16'hfeec, 2'b11, 16'ha507);
    rdc(16'hfeec, 16'h1f00);
  endtask
  task t_interval;
    wb(1'b1, 16'hfeec, 2'b11, 16'ha520);
    wb(1'b1, 16'hfeec, 2'b11, 16'h5afe);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk({15'h0000, irq}, 16'h0001);
    wb(1'b1, 16'hfeec, 2'b11, 16'ha520);
    @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0001);
    wb(1'b0, 16'hfeec, 2'b11, 16'h0000);
    chk({rd[15:8], 8'h00}, 16'hb800);
    wb(1'b1, 16'hfeec, 2'b11, 16'ha520);
    @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0000);
    wb(1'b1, 16'hfeec, 2'b11, 16'ha521);
    wb(1'b1, 16'hfeec, 2'b11, 16'h5afe);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk({15'h0000, n >= 34 && n <= 65}, 16'h0001);
  endtask
  task t_standby;
    wb(1'b1, 16'hfeec, 2'b11, 16'ha526);
    @(posedge sys_clk);
    sby <= 1'b1;
    @(posedge sys_clk);
    sby <= 1'b0;
    rdc(16'hfeec, 16'h1e00);
  endtask
  task t_watchdog;
    wb(1'b1, 16'hff14, 2'b11, 16'h5a40);
    rdc(16'hff14, 16'h007f);
    wb(1'b1, 16'hfeec, 2'b11, 16'ha560);
    wb(1'b1, 16'hfeec, 2'b11, 16'h5afe);
    n = 0;
    while (crst !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk({14'h0000, crst, irq}, 16'h0002);
    chk({15'h0000, poe_n}, 16'h0000);
    n = 0;
    while (crst === 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n[15:0], 16'(`WIT_RES_PULSE_CYC));
    chk({15'h0000, poe_n}, 16'h0001);
    rdc(16'hff14, 16'h00ff);
    wb(1'b1, 16'hff14, 2'b11, 16'ha500);
    rdc(16'hff14, 16'h007f);
  endtask
  // reset held 8 cycles; first request well after the synchroniser releases
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset_vals;
    t_password;
    t_interval;
    t_standby;
    t_watchdog;
    close_out;
  end
  // whole run needs under a thousand cycles
  initial begin
    #200000;
    err_count++;
    close_out;
  end
endmodule // wit_tb_top

// >>> src/wit_consts.vh
`ifndef WIT_CONSTS_VH
`define WIT_CONSTS_VH

// register addresses (byte addresses, word lane chosen by sel)
`define WIT_ADR_CTRL_WR 16'hfeec
`define WIT_ADR_CTRL_RD 16'hfeec
`define WIT_ADR_CNT_RD 16'hfeed
`define WIT_ADR_RST_WR 16'hff14
`define WIT_ADR_RST_RD 16'hff15

// passwords carried in the upper byte of a word write
`define WIT_PW_COUNT 8'h5a
`define WIT_PW_CTRL 8'ha5
`define WIT_PW_RST_CLR 8'ha5
`define WIT_PW_RST_OE 8'h5a
`define WIT_RST_CLR_DATA 8'h00

// control/status field positions
`define WIT_BIT_OVF 7
`define WIT_BIT_MODE 6
`define WIT_BIT_RUN 5
`define WIT_BIT_RFLAG 7
`define WIT_BIT_ROE 6

// reset values
`define WIT_CTRL_RESET 8'h18
`define WIT_CNT_RESET 8'h00
`define WIT_RST_RESET 8'h3f
`define WIT_CTRL_FIXED_ONES 8'h18
`define WIT_RST_FIXED_ONES 8'h3f

// timing
`define WIT_RES_PULSE_CYC 132
`define WIT_PRESC_W 12

`endif

// >>> src/wit_prescaler.v
`timescale 1ns/1ns
`include "wit_consts.vh"

module wit_prescaler #(
  parameter W = `WIT_PRESC_W
) (
  sys_clk,
  rst_n,
  div_sel,
  tick
);
  input wire sys_clk;
  input wire rst_n;
  input wire [2:0] div_sel;
  output wire tick;

  reg [W-1:0] presc_reg;
  wire [W-1:0] presc_next;

  // number of low prescaler bits that must be all ones for a tick
  function [3:0] div_bits;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: div_bits = 4'h1;
        3'h1: div_bits = 4'h5;
        3'h2: div_bits = 4'h6;
        3'h3: div_bits = 4'h7;
        3'h4: div_bits = 4'h8;
        3'h5: div_bits = 4'h9;
        3'h6: div_bits = 4'hb;
        default: div_bits = 4'hc;
      endcase
    end
  endfunction

  wire [W-1:0] mask = ~({W{1'b1}} << div_bits(div_sel));

  // free-running divider; a tick marks every 2^n-th clock
  assign presc_next = presc_reg + {{(W-1){1'b0}}, 1'b1};
  assign tick = ((presc_reg & mask) == mask);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= {W{1'b0}};
    end else begin
      presc_reg <= presc_next;
    end
  end
endmodule // wit_prescaler

// >>> src/wit_top.v
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`include "wit_consts.vh"

module wit_top #(
  parameter PULSE_CYC = `WIT_RES_PULSE_CYC
) (
  sys_clk,
  nrst,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  standby_req,
  interval_irq,
  chip_reset_out,
  res_pin_in,
  res_pin_out,
  res_pin_oe_n
);
  input wire sys_clk;
  input wire nrst;
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [15:0] wb_adr_i;
  input wire [1:0] wb_sel_i;
  input wire [15:0] wb_dat_i;
  output wire [15:0] wb_dat_o;
  output wire wb_ack_o;
  input wire standby_req;
  output wire interval_irq;
  output wire chip_reset_out;
  input wire res_pin_in;
  output wire res_pin_out;
  output wire res_pin_oe_n;

  // reset release through two flops; assertion stays asynchronous
  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_n;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // state
  reg [7:0] count_reg;
  reg [7:0] count_next;
  reg ovf_reg;
  reg ovf_next;
  reg mode_reg;
  reg mode_next;
  reg run_reg;
  reg run_next;
  reg [2:0] div_reg;
  reg [2:0] div_next;
  reg ovf_armed_reg;
  reg ovf_armed_next;
  reg rflag_reg;
  reg rflag_next;
  reg roe_reg;
  reg roe_next;
  reg [7:0] pulse_cnt_reg;
  reg [7:0] pulse_cnt_next;
  reg pulse_ext_reg;
  reg pulse_ext_next;
  reg ack_reg;
  reg [15:0] rdata_reg;
  reg [15:0] rdata_next;

  wire tick;

  wit_prescaler #(
    .W(`WIT_PRESC_W)
  ) u_presc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .div_sel(div_reg),
    .tick(tick)
  );

  // wishbone decode; the request is held until ack, so writes commit on the ack edge
  wire req = wb_cyc_i & wb_stb_i;
  // word-aligned match of a bus address against a register byte address; bit 0 only picks the lane
  function adr_match;
    input [15:0] adr;
    input [15:0] reg_adr;
    begin
      adr_match = (adr[15:1] == reg_adr[15:1]);
    end
  endfunction
  wire wr_commit = req & ack_reg & wb_we_i;
  wire rd_commit = req & ack_reg & ~wb_we_i;
  wire word_wr = wr_commit & (wb_sel_i == 2'b11); // byte writes are dropped
  wire [7:0] pw = wb_dat_i[15:8];
  wire [7:0] wdat = wb_dat_i[7:0];

  // password
  wire wr_count = word_wr & adr_match(wb_adr_i, `WIT_ADR_CTRL_WR) & (pw == `WIT_PW_COUNT);
  wire wr_ctrl = word_wr & adr_match(wb_adr_i, `WIT_ADR_CTRL_WR) & (pw == `WIT_PW_CTRL);
  // reset control register write paths
  wire wr_rclr = word_wr & adr_match(wb_adr_i, `WIT_ADR_RST_WR) & (pw == `WIT_PW_RST_CLR) &
                 (wdat == `WIT_RST_CLR_DATA);
  wire wr_roe = word_wr & adr_match(wb_adr_i, `WIT_ADR_RST_WR) & (pw == `WIT_PW_RST_OE);

  // read of the control byte with the flag up arms the clear
  wire rd_ctrl = rd_commit & adr_match(wb_adr_i, `WIT_ADR_CTRL_RD) & wb_sel_i[1];

  // big-endian lanes: even address in the upper byte
  wire [7:0] ctrl_rd = {ovf_reg, mode_reg, run_reg, 2'b00, div_reg} | `WIT_CTRL_FIXED_ONES;
  wire [7:0] rst_rd = {rflag_reg, roe_reg, 6'h00} | `WIT_RST_FIXED_ONES;

  // counter step and overflow detection
  wire step = run_reg & tick;
  wire wrap = step & (count_reg == 8'hff) & ~wr_count;
  wire wd_fire = wrap & mode_reg;
  wire pulse_active = (pulse_cnt_reg != 8'h00);

  // registered read data, mapped addresses only; others read zero
  always @* begin
    rdata_next = 16'h0000;
    if (adr_match(wb_adr_i, `WIT_ADR_CTRL_RD)) begin
      rdata_next = {ctrl_rd, count_reg};
    end else if (adr_match(wb_adr_i, `WIT_ADR_RST_RD)) begin
      rdata_next = {8'h00, rst_rd};
    end
  end

  // timer control, counter and flag next state
  always @* begin
    count_next = count_reg;
    ovf_next = ovf_reg;
    mode_next = mode_reg;
    run_next = run_reg;
    div_next = div_reg;
    ovf_armed_next = ovf_armed_reg;
    if (step) begin
      count_next = count_reg + 8'h01;
    end
    if (wr_count) begin
      count_next = wdat;
    end
    if (rd_ctrl & ovf_reg) begin
      ovf_armed_next = 1'b1;
    end
    if (wr_ctrl) begin
      mode_next = wdat[`WIT_BIT_MODE];
      run_next = wdat[`WIT_BIT_RUN];
      div_next = wdat[2:0];
      // a written one never sets the flag; a zero clears only after the read
      if (!wdat[`WIT_BIT_OVF] && ovf_armed_reg) begin
        ovf_next = 1'b0;
        ovf_armed_next = 1'b0;
      end
      if (!wdat[`WIT_BIT_RUN]) begin
        count_next = `WIT_CNT_RESET;
      end
    end
    // set beats a clear landing in the same cycle
    if (wrap && !mode_reg) begin
      ovf_next = 1'b1;
    end
    if (!run_reg && !wr_ctrl) begin
      count_next = `WIT_CNT_RESET;
    end
    // standby drops bits 7 to 5 but keeps the divider
    if (standby_req) begin
      ovf_next = 1'b0;
      mode_next = 1'b0;
      run_next = 1'b0;
      ovf_armed_next = 1'b0;
      count_next = `WIT_CNT_RESET;
    end
    // watchdog reset clears the timer as the whole chip does
    if (wd_fire || pulse_active) begin
      count_next = `WIT_CNT_RESET;
      ovf_next = 1'b0;
      mode_next = 1'b0;
      run_next = 1'b0;
      div_next = 3'h0;
      ovf_armed_next = 1'b0;
    end
  end

  // reset control register and pulse timing next state
  always @* begin
    rflag_next = rflag_reg;
    roe_next = roe_reg;
    pulse_cnt_next = pulse_cnt_reg;
    pulse_ext_next = pulse_ext_reg;
    if (wr_rclr) begin
      rflag_next = 1'b0;
    end
    if (wr_roe) begin
      roe_next = wdat[`WIT_BIT_ROE];
    end
    if (pulse_active) begin
      pulse_cnt_next = pulse_cnt_reg - 8'h01;
      if (pulse_cnt_reg == 8'h01) begin
        pulse_ext_next = 1'b0;
      end
    end
    // overflow wins over a clear write in the same cycle
    if (wd_fire) begin
      rflag_next = 1'b1;
      pulse_cnt_next = PULSE_CYC[7:0];
      pulse_ext_next = roe_reg;
    end
  end

  // wishbone ack: one wait state, dropped the cycle after it is given
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      rdata_reg <= rdata_next;
    end
  end

  // timer state; watchdog reset is handled in the next-state logic
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `WIT_CNT_RESET;
      ovf_reg <= 1'b0;
      mode_reg <= 1'b0;
      run_reg <= 1'b0;
      div_reg <= 3'h0;
      ovf_armed_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      ovf_reg <= ovf_next;
      mode_reg <= mode_next;
      run_reg <= run_next;
      div_reg <= div_next;
      ovf_armed_reg <= ovf_armed_next;
    end
  end

  // pin reset clears flag and enable; the watchdog reset itself does not
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rflag_reg <= 1'b0;
      roe_reg <= 1'b0;
      pulse_cnt_reg <= 8'h00;
      pulse_ext_reg <= 1'b0;
    end else begin
      rflag_reg <= rflag_next;
      roe_reg <= roe_next;
      pulse_cnt_reg <= pulse_cnt_next;
      pulse_ext_reg <= pulse_ext_next;
    end
  end

  // interrupt level follows the flag, which only interval mode sets
  assign interval_irq = ovf_reg & ~mode_reg;

  // internal chip reset lasts the pulse window
  assign chip_reset_out = pulse_active;

  // reset pin driven low for the whole pulse if enabled when the watchdog fires
  assign res_pin_out = 1'b0;
  assign res_pin_oe_n = ~pulse_ext_reg;

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
endmodule // wit_top
